// File: core/mfc_timing.v
/*
  format and timing control of an emissive microdisplay: display-on
  gating, scan direction, vertical and horizontal positioning in the
  spare margin, progressive and interlaced fields, stereo masking by
  the enable input, and the row-reset duty function in progressive scan.
  assumes syncs, data enable and pixel data synchronous to sys_clk_i,
  syncs active high, and a back porch of at least 48 clocks.
  assumes vsync falls before the first programmed row of a frame.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfc_timing_map.vh"

module mfc_timing #(
  parameter DW = 24,
  parameter ROWS = 1224,
  parameter COLS = 1944
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [2:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output reg [15:0] reg_rdata_o,
  input wire hsync_i,
  input wire vsync_i,
  input wire de_i,
  input wire [DW-1:0] pix_i,
  input wire enable_i,
  output reg pix_we_o,
  output reg [10:0] pix_col_o,
  output reg [DW-1:0] pix_data_o,
  output reg row_prog_o,
  output reg [10:0] row_addr_o,
  output reg row_blank_o,
  output reg row_black_pulse_o,
  output reg [10:0] row_black_addr_o,
  output reg field_o,
  output reg frame_acq_o
);

  // software registers
  reg [15:0] video_input_config;
  reg [15:0] display_config;
  reg [10:0] left_edge_position;
  reg [10:0] right_edge_position;
  reg [10:0] first_row_position;
  reg [10:0] last_row_position;
  reg [9:0] black_hold_lines;

  // decoded control bits
  wire en_pol = video_input_config[`MFC_ENABLE_POL_BIT];
  wire fld_pol = video_input_config[`MFC_FIELD_POL_BIT];
  wire blank = display_config[`MFC_BLANK_BIT];
  wire vdir = display_config[`MFC_VDIR_BIT];
  wire hdir = display_config[`MFC_HDIR_BIT];
  wire [1:0] scan_type = display_config[`MFC_SCAN_MSB:`MFC_SCAN_LSB];
  wire stereo = display_config[`MFC_STEREO_BIT];
  // scan codes other than progressive all count as interlaced
  wire interlaced = (scan_type != `MFC_SCAN_PROGRESSIVE);

  // enable synchroniser, previous sync levels
  reg en_meta;
  reg en_sync;
  reg hs_d;
  reg vs_d;
  reg en_cap; // enable level at the last vsync fall
  reg acq; // frame in acquisition
  reg [10:0] line_cnt; // hsync count since frame start
  reg [11:0] frame_rows; // lines counted in the last frame
  reg line_dark; // current line is written black
  reg [10:0] fill_cnt; // black fill position
  reg fill_run;
  reg [10:0] pix_cnt; // pixels in current line

  // enable active level; low polarity means low is active
  wire en_act = ~(en_sync ^ en_pol);
  // masked sync edges; inactive enable drops them, the vsync fall stays unmasked
  wire hs_ev = hsync_i & ~hs_d & en_act;
  wire vs_ev = vsync_i & ~vs_d & en_act;
  wire vs_fall = ~vsync_i & vs_d;

  // register write port
  // writes take effect on the next clock; no shadowing, so a
  // mid-frame row position change shows up from the next line, a column edge from the next pixel
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      video_input_config <= `MFC_VIC_RESET;
      display_config <= `MFC_DC_RESET;
      left_edge_position <= `MFC_LEFT_RESET;
      right_edge_position <= `MFC_RIGHT_RESET;
      first_row_position <= `MFC_TOP_RESET;
      last_row_position <= `MFC_BOTTOM_RESET;
      black_hold_lines <= `MFC_BLACK_HOLD_RESET;
    end
    else if (reg_we_i)
    begin
      // address decode; status is read only
      if (reg_addr_i == `MFC_VIDEO_INPUT_CONFIG)
        video_input_config <= {14'h0000, reg_wdata_i[1:0]};
      else if (reg_addr_i == `MFC_DISPLAY_CONFIG)
        display_config <= {10'h000, reg_wdata_i[5:0]};
      else if (reg_addr_i == `MFC_LEFT_EDGE_POSITION)
        left_edge_position <= reg_wdata_i[10:0];
      else if (reg_addr_i == `MFC_RIGHT_EDGE_POSITION)
        right_edge_position <= reg_wdata_i[10:0];
      else if (reg_addr_i == `MFC_FIRST_ROW_POSITION)
        first_row_position <= reg_wdata_i[10:0];
      else if (reg_addr_i == `MFC_LAST_ROW_POSITION)
        last_row_position <= reg_wdata_i[10:0];
      else if (reg_addr_i == `MFC_BLACK_HOLD_LINES)
        black_hold_lines <= reg_wdata_i[9:0];
    end
  end

  // register read port, data one cycle after the strobe
  // idle cycles return zero so a stray sample never looks valid
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_re_i)
    begin
      if (reg_addr_i == `MFC_VIDEO_INPUT_CONFIG)
        reg_rdata_o <= video_input_config;
      else if (reg_addr_i == `MFC_DISPLAY_CONFIG)
        reg_rdata_o <= display_config;
      else if (reg_addr_i == `MFC_LEFT_EDGE_POSITION)
        reg_rdata_o <= {5'h00, left_edge_position};
      else if (reg_addr_i == `MFC_RIGHT_EDGE_POSITION)
        reg_rdata_o <= {5'h00, right_edge_position};
      else if (reg_addr_i == `MFC_FIRST_ROW_POSITION)
        reg_rdata_o <= {5'h00, first_row_position};
      else if (reg_addr_i == `MFC_LAST_ROW_POSITION)
        reg_rdata_o <= {5'h00, last_row_position};
      else if (reg_addr_i == `MFC_BLACK_HOLD_LINES)
        reg_rdata_o <= {6'h00, black_hold_lines};
      else
        // status: acquisition, field, caught enable, line count
        reg_rdata_o <= {acq, field_o, en_cap, 2'h0, line_cnt};
    end
    else
      reg_rdata_o <= 16'h0000;
  end

  // enable synchroniser; only the second stage is used
  // the enable may come from graphics software with no relation
  // to the syncs; two stages keep a metastable level out
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      hs_d <= 1'b0;
      vs_d <= 1'b0;
    end
    else
    begin
      en_meta <= enable_i;
      en_sync <= en_meta;
      hs_d <= hsync_i;
      vs_d <= vsync_i;
    end
  end

  // field and frame decision caught at the vsync fall
  // the caught value steers the whole following frame
  // limitation: a level change within two clocks of the fall
  // may land in either frame
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      en_cap <= 1'b0;
      field_o <= 1'b0;
      acq <= 1'b1;
      frame_acq_o <= 1'b1;
    end
    else if (vs_fall)
    begin
      en_cap <= en_sync;
      if (stereo && interlaced)
        // active enable gets odd field when polarity is 0
        field_o <= ~((~(en_sync ^ en_pol)) ^ fld_pol);
      else
        // low means odd field unless polarity swaps it
        field_o <= en_sync ^ fld_pol;
      // stereo: inactive eye holds its image for next frame
      acq <= stereo ? ~(en_sync ^ en_pol) : 1'b1;
      frame_acq_o <= stereo ? ~(en_sync ^ en_pol) : 1'b1;
    end
  end

  // line counting; frame start resets, length kept for wrap
  // saturates rather than wraps so a missing vsync cannot alias
  // line numbers back onto real rows
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      line_cnt <= 11'h000;
      frame_rows <= 12'h000;
    end
    else if (vs_ev)
    begin
      line_cnt <= 11'h000;
      // full line count of the frame just ended is the wrap
      // distance; the black pulse counts hsync periods, and
      // blanking lines belong to that distance as well
      if (line_cnt > `MFC_INIT_LINES)
        frame_rows <= {1'b0, line_cnt} + 12'h001;
    end
    else if (hs_ev && line_cnt != 11'h7ff)
      line_cnt <= line_cnt + 11'h001;
  end

  // line number this hsync starts; the count itself only
  // moves on the same edge, so the row would lag one line
  wire [10:0] line_nxt = vs_ev ? 11'h000
    : (line_cnt == 11'h7ff) ? line_cnt : line_cnt + 11'h001;
  // row under programming in the line just started
  wire [10:0] k = line_nxt - `MFC_INIT_LINES;
  wire in_rows = (line_nxt >= `MFC_INIT_LINES);
  // interlaced fields take every other row
  wire [11:0] r_full = interlaced ? {k, field_o} : {1'b0, k};
  wire [10:0] r = r_full[10:0];
  wire r_ok = (r_full < ROWS);
  // outside the window the row is written black
  wire r_win = (r >= first_row_position) && (r <= last_row_position);
  // row that is reset now: 2*W lines before its next write
  wire [11:0] rb_sum = {1'b0, k} + {1'b0, black_hold_lines, 1'b0};
  wire [11:0] rb_wrap = (rb_sum >= frame_rows && frame_rows != 12'h000)
    ? rb_sum - frame_rows : rb_sum;
  wire rb_ok = (rb_wrap < ROWS);
  // mirrored row numbers, cut back to the address width
  wire [31:0] r_flip = ROWS - 1 - r;
  wire [31:0] rb_flip = ROWS - 1 - rb_wrap;

  // row sequencer; held frames write nothing
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      row_prog_o <= 1'b0;
      row_addr_o <= 11'h000;
      row_blank_o <= 1'b1;
      line_dark <= 1'b1;
      row_black_pulse_o <= 1'b0;
      row_black_addr_o <= 11'h000;
    end
    else
    begin
      row_prog_o <= 1'b0;
      row_black_pulse_o <= 1'b0;
      // pixels of init lines, held frames and rows outside
      // the window all go out black; row_blank_o alone would
      // keep a stale level on lines that program no row
      if (hs_ev)
        line_dark <= blank | ~(acq & in_rows & r_ok) | ~r_win;
      if (hs_ev && acq && in_rows)
      begin
        if (r_ok)
        begin
          row_prog_o <= 1'b1;
          // reversed order counts rows from the far edge
          row_addr_o <= vdir ? r_flip[10:0] : r;
          row_blank_o <= blank | ~r_win;
        end
        // zero hold never issues a black pulse
        if (black_hold_lines != 10'h000 && rb_ok && !interlaced)
        begin
          row_black_pulse_o <= 1'b1;
          row_black_addr_o <= vdir ? rb_flip[10:0] : rb_wrap[10:0];
        end
      end
    end
  end

  // column position of the current input pixel
  // positions are absolute columns; left above right writes
  // no lit pixel at all
  wire [10:0] col_in = left_edge_position + pix_cnt;
  wire col_ok = (col_in <= right_edge_position) && (col_in < COLS);
  // fill walks left margin, then the right margin
  wire fill_left = (fill_cnt < left_edge_position);
  wire [10:0] fill_col = fill_left ? fill_cnt
    : right_edge_position + 11'h001 + (fill_cnt - left_edge_position);
  wire fill_done = ~fill_left && (fill_col >= COLS);
  // mirrored columns, cut back to the address width
  wire [31:0] col_flip = COLS - 1 - col_in;
  wire [31:0] fill_flip = COLS - 1 - fill_col;

  // horizontal shifter; margin black written in back porch
  // limitation: needs porch of left plus right margin clocks
  // trade-off: black margins are written, not masked, so the
  // column memory needs no clear between frames
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pix_cnt <= 11'h000;
      fill_cnt <= 11'h000;
      fill_run <= 1'b0;
      pix_we_o <= 1'b0;
      pix_col_o <= 11'h000;
      pix_data_o <= {DW{1'b0}};
    end
    else
    begin
      pix_we_o <= 1'b0;
      if (hs_ev)
      begin
        // new line: restart both walks
        pix_cnt <= 11'h000;
        fill_cnt <= 11'h000;
        fill_run <= acq;
      end
      else if (de_i && en_act && acq)
      begin
        // active pixel, black beyond the right edge
        pix_cnt <= pix_cnt + 11'h001;
        if (col_in < COLS)
        begin
          pix_we_o <= 1'b1;
          pix_col_o <= hdir ? col_flip[10:0] : col_in;
          pix_data_o <= (line_dark | ~col_ok) ? {DW{1'b0}} : pix_i;
        end
      end
      else if (fill_run)
      begin
        // a frame put on hold at the vsync fall stops the fill too
        if (fill_done || !acq)
          fill_run <= 1'b0;
        else
        begin
          // black margin pixel
          pix_we_o <= 1'b1;
          pix_col_o <= hdir ? fill_flip[10:0] : fill_col;
          pix_data_o <= {DW{1'b0}};
          fill_cnt <= fill_cnt + 11'h001;
        end
      end
    end
  end

endmodule // mfc_timing
`default_nettype wire

// File: core/mfc_timing_map.vh
/*
  register offsets, field positions, reset values and fixed counts
  for the microdisplay format and timing control.
  assumes inclusion by bare name from the design file.
*/
`ifndef MFC_TIMING_MAP_VH
`define MFC_TIMING_MAP_VH

// register offsets on the 3-bit register port
`define MFC_VIDEO_INPUT_CONFIG 3'h0
`define MFC_DISPLAY_CONFIG 3'h1
`define MFC_LEFT_EDGE_POSITION 3'h2
`define MFC_RIGHT_EDGE_POSITION 3'h3
`define MFC_FIRST_ROW_POSITION 3'h4
`define MFC_LAST_ROW_POSITION 3'h5
`define MFC_BLACK_HOLD_LINES 3'h6
`define MFC_STATUS 3'h7

// video_input_config fields
`define MFC_ENABLE_POL_BIT 0
`define MFC_FIELD_POL_BIT 1

// display_config fields
`define MFC_BLANK_BIT 0
`define MFC_VDIR_BIT 1
`define MFC_HDIR_BIT 2
`define MFC_SCAN_LSB 3
`define MFC_SCAN_MSB 4
`define MFC_STEREO_BIT 5

// scan type codes
`define MFC_SCAN_PROGRESSIVE 2'h0

// reset values: array blank, window centred in the spare margin
`define MFC_VIC_RESET 16'h0000
`define MFC_DC_RESET 16'h0001
`define MFC_LEFT_RESET 11'h00c
`define MFC_RIGHT_RESET 11'h78b
`define MFC_TOP_RESET 11'h00c
`define MFC_BOTTOM_RESET 11'h4bb
`define MFC_BLACK_HOLD_RESET 10'h000

// initialization line scans ahead of row 0 in each frame
`define MFC_INIT_LINES 11'h002

`endif

// File: sim/mfc_timing_properties.sv
/* port checker for mfc_timing.
   assumes binding onto mfc_timing, syncs from the video source. */
`timescale 1ns/1ps
`default_nettype none
module mfc_timing_properties #(
  parameter DW = 24
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reg_re_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic pix_we_o,
  input wire logic [DW-1:0] pix_data_o,
  input wire logic row_prog_o,
  input wire logic row_blank_o,
  input wire logic row_black_pulse_o,
  input wire logic field_o,
  input wire logic frame_acq_o
);
  // one clock domain, so one default clock and reset
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // read data only in the cycle after a read strobe
  chk_rdata_idle:
    assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000) else $error("rdata not idle");
  chk_prog_hs_edge:
    assert property (row_prog_o |-> $past(hsync_i) && !$past(hsync_i, 2)) else $error("prog late");
  chk_prog_pulse:
    assert property (row_prog_o |=> !row_prog_o) else $error("prog too long");
  chk_blank_black:
    assert property (pix_we_o && row_blank_o |-> pix_data_o == '0) else $error("blank row lit");
  // a held image must not be rewritten
  chk_masked_quiet:
    assert property (!frame_acq_o |-> !row_prog_o && !pix_we_o) else $error("write while held");
  chk_field_hold:
    assert property (vsync_i && $past(vsync_i) |-> $stable(field_o)) else $error("field moved");
  chk_acq_at_fall:
    assert property ($changed(frame_acq_o) |-> !vsync_i) else $error("acq moved in vsync");
  chk_pulse_with_prog:
    assert property (row_black_pulse_o |-> row_prog_o) else $error("pulse off line start");
  chk_pulse_single:
    assert property (row_black_pulse_o |=> !row_black_pulse_o [*4]) else $error("pulse too long");
endmodule // mfc_timing_properties
bind mfc_timing mfc_timing_properties #(.DW(DW)) i_chk (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .hsync_i(hsync_i),
  .vsync_i(vsync_i), .pix_we_o(pix_we_o), .pix_data_o(pix_data_o), .row_prog_o(row_prog_o),
  .row_blank_o(row_blank_o), .row_black_pulse_o(row_black_pulse_o), .field_o(field_o),
  .frame_acq_o(frame_acq_o));
`default_nettype wire

// File: sim/mfc_video_src.sv
/* video source model: syncs, data enable, pixels and stereo enable.
   assumes frame() is called from the bench, one line is 100 clocks. */
`timescale 1ns/1ps
`default_nettype none
module mfc_video_src #(
  parameter int DW = 24
) (
  input wire logic clk_i,
  input wire logic en_lvl_i,
  output logic hsync_o,
  output logic vsync_o,
  output logic de_o,
  output logic [DW-1:0] pix_o,
  output logic enable_o
);
  // enable idles low for plain use
  initial
  begin
    hsync_o = 1'b0;
    vsync_o = 1'b0;
    de_o = 1'b0;
    pix_o = '0;
    enable_o = 1'b0;
  end
  // stereo sync from software, unrelated to the syncs
  always @(posedge clk_i) enable_o <= en_lvl_i;
  // one line: 4 sync clocks, 48 porch, 40 pixels, 8 front porch
  task automatic line(input bit vs);
    for (int c = 0; c < 100; c++)
    begin
      @(posedge clk_i);
      vsync_o <= vs;
      hsync_o <= (c < 4);
      de_o <= (c >= 52 && c < 92);
      // eye marked by enable level; idle bus shows inverted junk
      pix_o <= (c >= 52 && c < 92) ? DW'({enable_o ? 8'h1c : 8'h2d, 8'h01, 8'(c)}) : ~pix_o;
    end
  endtask
  // one vsync line, so the fall lands before the first row line
  task automatic frame(input int nl);
    for (int i = 0; i < nl; i++)
      line(i < 1);
  endtask
endmodule // mfc_video_src
`default_nettype wire

// File: sim/tb_mfc_timing.sv
/* self-checking bench for mfc_timing.
   assumes a shrunk 20x48 array and the video source model. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_mfc_timing;
  localparam int R = 20;
  logic clk, rst, we, re, hs, vs, de, en, en_pin, pwe, rp, rb, bp, fld, acq;
  logic [2:0] addr;
  logic [15:0] wd, rdata;
  logic [23:0] pix, pdat;
  logic [10:0] pcol, ra, ba;
  int bad_count, checks, n_prog, first_row, first_col, n_pulse, pulse_bad, nz_in, nz_out;
  mfc_video_src #(.DW(24)) i_src (.clk_i(clk), .en_lvl_i(en), .hsync_o(hs), .vsync_o(vs),
    .de_o(de), .pix_o(pix), .enable_o(en_pin));
  mfc_timing #(.DW(24), .ROWS(R), .COLS(48)) i_dut (.sys_clk_i(clk), .rst_i(rst),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .hsync_i(hs), .vsync_i(vs), .de_i(de), .pix_i(pix), .enable_i(en_pin), .pix_we_o(pwe),
    .pix_col_o(pcol), .pix_data_o(pdat), .row_prog_o(rp), .row_addr_o(ra), .row_blank_o(rb),
    .row_black_pulse_o(bp), .row_black_addr_o(ba), .field_o(fld), .frame_acq_o(acq));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // sampled on the falling edge so the outputs have settled
  always @(negedge clk)
  if (!rst)
  begin
    if (rp && first_row < 0) first_row = ra;
    if (rp && !rb) n_prog++;
    if (pwe && first_col < 0) first_col = pcol;
    if (pwe && pdat != 0 && (pcol < 2 || pcol > 41)) nz_out++;
    if (pwe && pdat != 0 && pcol >= 2 && pcol <= 41) nz_in++;
    if (bp) n_pulse++;
    // rows near the wrap skipped, wrap length is frame dependent
    if (bp && ra + 6 < R && ba !== ra + 11'h006) pulse_bad++;
  end
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  task automatic frm(input logic e);
    en <= e;
    first_row = -1;
    first_col = -1;
    {n_prog, n_pulse, pulse_bad, nz_in, nz_out} = '0;
    // the enable needs three clocks to reach the sync masks
    repeat (4) @(posedge clk);
    i_src.frame(R + 2);
    repeat (20) @(posedge clk);
  endtask
  task automatic t_regs;
    logic [15:0] rv [7];
    rv = '{16'h0000, 16'h0001, 16'h000c, 16'h078b, 16'h000c, 16'h04bb, 16'h0000};
    `CHK("blank", 1'b1, rb)
    for (int i = 0; i < 7; i++)
      rd(3'(i), rv[i]);
    wr(3'h7, 16'hffff);
    rd(3'h7, 16'h8000);
    wr(3'h0, 16'hffff);
    rd(3'h0, 16'h0003);
    wr(3'h0, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_window;
    frm(1'b0);
    `CHK("rows", 0, n_prog)
    `CHK("lit", 0, nz_in + nz_out)
    wr(3'h2, 16'h0002);
    wr(3'h3, 16'h0029);
    wr(3'h4, 16'h0002);
    wr(3'h5, 16'h0011);
    wr(3'h1, 16'h0000);
    frm(1'b0);
    `CHK("rows", 16, n_prog)
    `CHK("in", 640, nz_in)
    `CHK("out", 0, nz_out)
    `CHK("row0", 0, first_row)
    $display("t_window done");
  endtask
  task automatic t_dir;
    wr(3'h1, 16'h0006);
    frm(1'b0);
    `CHK("vdir", 19, first_row)
    `CHK("hdir", 47, first_col)
    wr(3'h1, 16'h0000);
    $display("t_dir done");
  endtask
  task automatic t_black;
    wr(3'h6, 16'h0003);
    frm(1'b0);
    `CHK("pulse", 1'b1, n_pulse > 0)
    `CHK("paddr", 0, pulse_bad)
    wr(3'h6, 16'h0000);
    frm(1'b0);
    `CHK("nopulse", 0, n_pulse)
    $display("t_black done");
  endtask
  // enable polarity follows the level so the syncs stay unmasked
  task automatic t_field;
    wr(3'h1, 16'h0008);
    for (int k = 0; k < 4; k++)
    begin
      wr(3'h0, 16'(k));
      frm(k[0]);
      `CHK("field", k[0] ^ k[1], fld)
      `CHK("row0", k[0] ^ k[1], first_row)
    end
    $display("t_field done");
  endtask
  task automatic t_stereo;
    wr(3'h1, 16'h0020);
    for (int k = 0; k < 4; k++)
    begin
      wr(3'h0, 16'(k[0]));
      frm(k[1]);
      `CHK("acq", k[0] == k[1], acq)
      `CHK("rows", (k[0] == k[1]) ? 16 : 0, n_prog)
    end
    wr(3'h1, 16'h0028);
    for (int f = 0; f < 2; f++)
    begin
      wr(3'h0, 16'(2 * f + 1));
      frm(1'b1);
      `CHK("sfield", f[0], fld)
    end
    $display("t_stereo done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // cut a hang after about twice the expected run
  initial
  begin
    repeat (70000) @(posedge clk);
    bad_count++;
    $display("watchdog expired");
    test_done;
  end
  initial
  begin
    {rst, we, re, addr, wd, en, bad_count, checks} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_window;
    t_dir;
    t_black;
    t_field;
    t_stereo;
    test_done;
  end
endmodule // tb_mfc_timing
`default_nettype wire
